// File: i2c_target_pkg.sv
// shared constants, carrier types and state codes of the two-wire target port
package i2c_target_pkg;

    // factory-set 7-bit target address
    localparam logic [6:0] OWN_ADDR = 7'h6D;
    // address or data bits in one byte, before the acknowledge period
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // byte sent when the read answer has not come back in time
    localparam logic [7:0] LATE_READ_BYTE = 8'hFF;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LEVEL_LOW = 1'b0;
    localparam logic RESET_ASSERTED = 1'b1;

    // one register write handed to the register side
    typedef struct packed {
        logic [7:0] reg_addr;
        logic [7:0] data;
    } wr_word_t;

    typedef enum logic [6:0] {
        ST_IDLE      = 7'h01,
        ST_ADDR      = 7'h02,
        ST_ADDR_ACK  = 7'h04,
        ST_WRITE     = 7'h08,
        ST_WRITE_ACK = 7'h10,
        ST_READ      = 7'h20,
        ST_READ_ACK  = 7'h40
    } link_state_t;

endpackage

// File: sync_bit.sv
// two-flop synchroniser for one level, with a constant reset value
`timescale 1ns/10ps
module sync_bit
    import i2c_target_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);

    logic meta_r;

    // the first flop feeds only the second one
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end

endmodule

// File: pair_buffer.sv
// two-entry buffer: registered output entry plus one skid entry
`timescale 1ns/10ps
module pair_buffer
    import i2c_target_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    logic [WIDTH-1:0] skid_r;
    logic skid_valid_r;

    // full only when both entries hold a word
    assign in_ready_out = ~skid_valid_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
            skid_r <= '0;
            skid_valid_r <= 1'b0;
        end else if (out_ready_in || !out_valid_out) begin
            if (skid_valid_r) begin
                out_data_out <= skid_r;
                out_valid_out <= 1'b1;
                skid_valid_r <= 1'b0;
            end else begin
                out_valid_out <= in_valid_in;
                if (in_valid_in) begin
                    out_data_out <= in_data_in;
                end
            end
        end else if (in_valid_in && !skid_valid_r) begin
            skid_r <= in_data_in;
            skid_valid_r <= 1'b1;
        end
    end

endmodule

// File: sensor_i2c_target_port.sv
// two-wire bus target port: link engine on the link clock, register side on the system clock
//
// Notes on behaviour
// - answer only to the fixed 7-bit target address; others are ignored.
// - data falling while clock is high starts a transaction, also mid-transfer.
// - data rising while clock is high ends the transaction and returns to idle.
// - seven address bits then a direction bit choosing read or write.
// - on address match, hold data low through the whole ninth clock period.
// - data driven by this port changes only while the clock line is low.
`timescale 1ns/10ps
module sensor_i2c_target_port
    import i2c_target_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic LINK_CLK_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    output logic WR_VALID_OUT,
    input wire logic WR_READY_IN,
    output logic [7:0] WR_ADDR_OUT,
    output logic [7:0] WR_DATA_OUT,
    output logic RD_VALID_OUT,
    output logic [7:0] RD_ADDR_OUT,
    input wire logic [7:0] RD_DATA_IN,
    input wire logic RD_DATA_VALID_IN
);

    // ---------------- link domain ----------------
    logic link_rst;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;

    link_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic ptr_phase_r;
    logic [7:0] ptr_r;
    logic sda_oe_r;

    logic wr_req_r;
    wr_word_t wr_word_r;
    logic rd_req_r;
    logic [7:0] rd_addr_r;
    logic wr_ack_s;
    logic rd_ack_s;
    logic wr_busy;
    logic rd_wait;

    logic byte_end;
    logic addr_hit;
    logic load_tx;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] tx_byte;

    // ---------------- system domain ----------------
    logic wr_req_s;
    logic rd_req_s;
    logic wr_ack_r;
    logic rd_ack_r;
    logic rd_busy_r;
    logic [7:0] rd_addr_q_r;
    logic [7:0] rd_data_r;
    logic push_valid;
    logic push_ready;
    wr_word_t pop_word;

    // link reset: asserted at once, released on the link clock
    sync_bit #(.RESET_VAL(RESET_ASSERTED)) u_link_rst (
        .clk_in(LINK_CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(~RESET_ASSERTED),
        .q_out(link_rst)
    );

    sync_bit #(.RESET_VAL(LINE_IDLE)) u_scl_sync (
        .clk_in(LINK_CLK_IN),
        .rst_in(link_rst),
        .d_in(SCL_IN),
        .q_out(scl_s)
    );

    sync_bit #(.RESET_VAL(LINE_IDLE)) u_sda_sync (
        .clk_in(LINK_CLK_IN),
        .rst_in(link_rst),
        .d_in(SDA_IN),
        .q_out(sda_s)
    );

    sync_bit #(.RESET_VAL(1'b0)) u_wr_ack_sync (
        .clk_in(LINK_CLK_IN),
        .rst_in(link_rst),
        .d_in(wr_ack_r),
        .q_out(wr_ack_s)
    );

    sync_bit #(.RESET_VAL(1'b0)) u_rd_ack_sync (
        .clk_in(LINK_CLK_IN),
        .rst_in(link_rst),
        .d_in(rd_ack_r),
        .q_out(rd_ack_s)
    );

    always_ff @(posedge LINK_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            scl_d <= LINE_IDLE;
            sda_d <= LINE_IDLE;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;

    assign wr_busy = wr_req_r ^ wr_ack_s;
    assign rd_wait = rd_req_r ^ rd_ack_s;
    // rd_data_r is only changed while a request is open, so it is stable here
    assign tx_byte = rd_wait ? LATE_READ_BYTE : rd_data_r;

    assign byte_end = scl_fall & (bit_cnt_r == BITS_PER_BYTE);
    assign addr_hit = (state_r == ST_ADDR) & byte_end & (shift_r[7:1] == OWN_ADDR);
    assign load_tx = scl_fall & (((state_r == ST_ADDR_ACK) & rw_r) | (state_r == ST_READ_ACK));
    assign wr_fire = (state_r == ST_WRITE) & byte_end & ~ptr_phase_r & ~wr_busy;
    // read data is fetched one byte ahead so it is ready at the next load;
    // no new toggle while one is open, or the pair would cancel and rd_wait lie
    assign rd_fire = ~rd_wait & ((addr_hit & shift_r[0]) | load_tx);

    // link engine; SDA drive only moves on a sampled clock fall
    always_ff @(posedge LINK_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= BIT_CNT_RESET;
            shift_r <= BYTE_RESET;
            rw_r <= 1'b0;
            ptr_phase_r <= 1'b0;
            ptr_r <= PTR_RESET;
            sda_oe_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= BIT_CNT_RESET;
            sda_oe_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_end) begin
                        bit_cnt_r <= BIT_CNT_RESET;
                        if (addr_hit) begin
                            state_r <= ST_ADDR_ACK;
                            sda_oe_r <= 1'b1;
                            rw_r <= shift_r[0];
                            ptr_phase_r <= ~shift_r[0];
                        end else begin
                            // not ours: stay silent until the next start
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= BIT_CNT_RESET;
                        if (rw_r) begin
                            state_r <= ST_READ;
                            shift_r <= tx_byte;
                            sda_oe_r <= ~tx_byte[7];
                            ptr_r <= ptr_r + PTR_STEP;
                        end else begin
                            state_r <= ST_WRITE;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_end) begin
                        bit_cnt_r <= BIT_CNT_RESET;
                        state_r <= ST_WRITE_ACK;
                        if (ptr_phase_r) begin
                            ptr_r <= shift_r;
                            ptr_phase_r <= 1'b0;
                            sda_oe_r <= 1'b1;
                        end else begin
                            // a full register side refuses the byte with a nack
                            sda_oe_r <= ~wr_busy;
                            if (!wr_busy) begin
                                ptr_r <= ptr_r + PTR_STEP;
                            end
                        end
                    end
                end
                ST_WRITE_ACK: begin
                    if (scl_fall) begin
                        state_r <= ST_WRITE;
                        sda_oe_r <= 1'b0;
                    end
                end
                ST_READ: begin
                    if (scl_rise) begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_end) begin
                        state_r <= ST_READ_ACK;
                        bit_cnt_r <= BIT_CNT_RESET;
                        sda_oe_r <= 1'b0;
                    end else if (scl_fall) begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= ~shift_r[6];
                    end
                end
                ST_READ_ACK: begin
                    if (scl_rise && sda_s) begin
                        // master nack ends the read; wait for stop or start
                        state_r <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_r <= ST_READ;
                        shift_r <= tx_byte;
                        sda_oe_r <= ~tx_byte[7];
                        ptr_r <= ptr_r + PTR_STEP;
                    end
                end
            endcase
        end
    end

    // request toggles toward the system domain; payload held until answered
    always_ff @(posedge LINK_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            wr_req_r <= 1'b0;
            wr_word_r <= '0;
        end else if (wr_fire) begin
            wr_word_r <= '{reg_addr: ptr_r, data: shift_r};
            wr_req_r <= ~wr_req_r;
        end
    end

    always_ff @(posedge LINK_CLK_IN or posedge link_rst) begin
        if (link_rst) begin
            rd_req_r <= 1'b0;
            rd_addr_r <= PTR_RESET;
        end else if (rd_fire) begin
            rd_addr_r <= addr_hit ? ptr_r : ptr_r + PTR_STEP;
            rd_req_r <= ~rd_req_r;
        end
    end

    // open drain: only ever pulls low
    assign SDA_OUT = LEVEL_LOW;
    assign SDA_OE_OUT = sda_oe_r;

    // ---------------- system domain ----------------
    sync_bit #(.RESET_VAL(1'b0)) u_wr_req_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(wr_req_r),
        .q_out(wr_req_s)
    );

    sync_bit #(.RESET_VAL(1'b0)) u_rd_req_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(rd_req_r),
        .q_out(rd_req_s)
    );

    assign push_valid = wr_req_s ^ wr_ack_r;

    // the ack returns only once the buffer took the word: this is the back-pressure
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            wr_ack_r <= 1'b0;
        end else if (push_valid && push_ready) begin
            wr_ack_r <= ~wr_ack_r;
        end
    end

    pair_buffer #(.WIDTH($bits(wr_word_t))) u_wr_buf (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(wr_word_r),
        .out_valid_out(WR_VALID_OUT),
        .out_ready_in(WR_READY_IN),
        .out_data_out(pop_word)
    );

    assign WR_ADDR_OUT = pop_word.reg_addr;
    assign WR_DATA_OUT = pop_word.data;

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rd_busy_r <= 1'b0;
            rd_addr_q_r <= PTR_RESET;
            rd_data_r <= BYTE_RESET;
            rd_ack_r <= 1'b0;
        end else if (!rd_busy_r && (rd_req_s ^ rd_ack_r)) begin
            rd_busy_r <= 1'b1;
            rd_addr_q_r <= rd_addr_r;
        end else if (rd_busy_r && RD_DATA_VALID_IN) begin
            rd_busy_r <= 1'b0;
            rd_data_r <= RD_DATA_IN;
            rd_ack_r <= ~rd_ack_r;
        end
    end

    assign RD_VALID_OUT = rd_busy_r;
    assign RD_ADDR_OUT = rd_addr_q_r;

endmodule

// File: port_checker.sv
// concurrent checks on the ports of the two-wire target port
`timescale 1ns/10ps
module port_checker (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic LINK_CLK_IN,
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic WR_VALID_OUT,
    input wire logic WR_READY_IN,
    input wire logic [7:0] WR_ADDR_OUT,
    input wire logic [7:0] WR_DATA_OUT,
    input wire logic RD_VALID_OUT,
    input wire logic [7:0] RD_ADDR_OUT,
    input wire logic RD_DATA_VALID_IN
);
    // a driven bit stays driven for at least eight link clock cycles after it starts
    sequence oe_held;
        SDA_OE_OUT [*8];
    endsequence
    sequence rd_answer;
        RD_VALID_OUT && RD_DATA_VALID_IN;
    endsequence
    chk_oe_scl_low: assert property (@(posedge LINK_CLK_IN) disable iff (SYS_RST_IN)
        $changed(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN))
        else $error("data drive changed while the clock line was high");
    chk_ack_held: assert property (@(posedge LINK_CLK_IN) disable iff (SYS_RST_IN)
        $rose(SDA_OE_OUT) |=> oe_held)
        else $error("data drive released too early");
    chk_open_drain: assert property (@(posedge LINK_CLK_IN) disable iff (SYS_RST_IN)
        SDA_OE_OUT |-> !SDA_OUT)
        else $error("data line driven high");
    chk_wr_word_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        WR_VALID_OUT && !WR_READY_IN |=> WR_VALID_OUT && $stable({WR_ADDR_OUT, WR_DATA_OUT}))
        else $error("write word changed before it was taken");
    chk_rd_req_hold: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        RD_VALID_OUT && !RD_DATA_VALID_IN |=> RD_VALID_OUT && $stable(RD_ADDR_OUT))
        else $error("read request dropped before its answer");
    chk_rd_req_drop: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        rd_answer |=> !RD_VALID_OUT)
        else $error("read request stayed after its answer");
    chk_reset_quiet: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
        $fell(SYS_RST_IN) |-> !WR_VALID_OUT && !RD_VALID_OUT && !SDA_OE_OUT)
        else $error("outputs active right after reset");
endmodule
bind sensor_i2c_target_port port_checker chk (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .LINK_CLK_IN(LINK_CLK_IN), .SCL_IN(SCL_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .WR_VALID_OUT(WR_VALID_OUT),
    .WR_READY_IN(WR_READY_IN), .WR_ADDR_OUT(WR_ADDR_OUT), .WR_DATA_OUT(WR_DATA_OUT),
    .RD_VALID_OUT(RD_VALID_OUT), .RD_ADDR_OUT(RD_ADDR_OUT),
    .RD_DATA_VALID_IN(RD_DATA_VALID_IN)
);

// File: bus_master_model.sv
// bus controller model: pulls clock and data low or releases them to the pull-ups
`timescale 1ns/10ps
module bus_master_model (
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    // clock stands released between frames
    initial begin
        scl_low_out = 1'h0;
        sda_low_out = 1'h0;
    end
    task automatic put_bit(input logic b, output logic r);
        #96 sda_low_out = !b;
        #304 scl_low_out = 1'h0;
        #200 r = sda_in;
        #200 scl_low_out = 1'h1;
    endtask
    // also serves as a repeated start when the clock is held low
    task automatic start_cond();
        #96 sda_low_out = 1'h0;
        #304 scl_low_out = 1'h0;
        #400 sda_low_out = 1'h1;
        #400 scl_low_out = 1'h1;
    endtask
    task automatic stop_cond();
        #96 sda_low_out = 1'h1;
        #304 scl_low_out = 1'h0;
        #400 sda_low_out = 1'h0;
        #400;
    endtask
    task automatic put_byte(input logic [7:0] d, input logic b9, output logic [7:0] q,
                            output logic r9);
        for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
        put_bit(b9, r9);
    endtask
    task automatic addr_phase(input logic [6:0] a, input logic rd, output logic ack);
        logic [7:0] q;
        logic r;
        start_cond();
        put_byte({a, rd}, 1'h1, q, r);
        ack = !r;
    endtask
endmodule

// File: tb.sv
// self-checking bench of the two-wire target port
`timescale 1ns/10ps
`define CHK(g, e) check(16'(g), 16'(e))
module tb
    import i2c_target_pkg::*;
;
    logic clk = 1'h0, link_clk = 1'h0, rst = 1'h1, wr_ready = 1'h0, rd_dv = 1'h0, slow = 1'h0;
    logic [7:0] rd_data = 8'h00;
    logic scl_low, sda_low, wr_valid, rd_valid, oe, sda_out;
    logic [7:0] wr_addr, wr_data, rd_addr;
    wr_word_t got[$];
    int bad_count = 0, samples_checked = 0, wait_n = 0;
    wire scl = !scl_low;
    wire sda = !(sda_low | (oe & !sda_out));
    always #4 clk = !clk;
    always #15 link_clk = !link_clk;
    bus_master_model mst (.sda_in(sda), .scl_low_out(scl_low), .sda_low_out(sda_low));
    sensor_i2c_target_port uut (
        .CLK_IN(clk), .SYS_RST_IN(rst), .LINK_CLK_IN(link_clk), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE_OUT(oe), .WR_VALID_OUT(wr_valid), .WR_READY_IN(wr_ready),
        .WR_ADDR_OUT(wr_addr), .WR_DATA_OUT(wr_data), .RD_VALID_OUT(rd_valid),
        .RD_ADDR_OUT(rd_addr), .RD_DATA_IN(rd_data), .RD_DATA_VALID_IN(rd_dv)
    );
    // register side answers after 2 cycles, or after 120 to miss the whole ack period
    always @(negedge clk) begin
        rd_dv <= rd_valid && !rd_dv && (wait_n == (slow ? 120 : 2));
        if (rd_valid && !rd_dv) begin
            wait_n <= (wait_n == (slow ? 120 : 2)) ? 0 : wait_n + 1;
            if (wait_n == (slow ? 120 : 2)) rd_data <= rd_addr ^ 8'h5A;
        end
    end
    always @(posedge clk) if (wr_valid && wr_ready) got.push_back({wr_addr, wr_data});
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic r;
        mst.put_byte(d, 1'h1, q, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] q);
        logic r;
        mst.put_byte(8'hFF, !more, q, r);
    endtask
    task automatic t_write();
        logic a0, a1, a2, r;
        mst.start_cond();
        for (int i = 0; i < 3; i++) mst.put_bit(1'h0, r);
        got.delete();
        mst.addr_phase(OWN_ADDR, 1'h0, a0);
        wbyte(8'h30, a1);
        wbyte(8'hA5, a2);
        mst.stop_cond();
        repeat (20) @(negedge clk);
        `CHK({a0, a1, a2}, 3'h7);
        `CHK(got.size(), 1);
        `CHK(got[0], 16'h30A5);
    endtask
    task automatic t_wrong_addr();
        logic a0, a1;
        logic [6:0] bad[2] = '{7'h6C, 7'h2D};
        foreach (bad[i]) begin
            got.delete();
            mst.addr_phase(bad[i], 1'h0, a0);
            wbyte(8'h30, a1);
            mst.stop_cond();
            repeat (20) @(negedge clk);
            `CHK({a0, a1, got.size() == 0}, 3'h1);
        end
    endtask
    task automatic t_read(input logic late);
        logic a0, a1, a2;
        logic [7:0] q0, q1;
        slow = late;
        mst.addr_phase(OWN_ADDR, 1'h0, a0);
        wbyte(8'h06, a1);
        mst.addr_phase(OWN_ADDR, 1'h1, a2);
        rbyte(!late, q0);
        if (!late) rbyte(1'h0, q1);
        mst.stop_cond();
        `CHK({a0, a1, a2}, 3'h7);
        `CHK(q0, late ? 8'hFF : 8'h5C);
        if (!late) `CHK(q1, 8'h5D);
    endtask
    // receiver stalls: words beyond the buffer are refused, none is lost
    task automatic t_stall();
        logic a0, a1;
        logic [4:0] acks;
        wr_ready = 1'h0;
        got.delete();
        mst.addr_phase(OWN_ADDR, 1'h0, a0);
        wbyte(8'h40, a1);
        for (int i = 0; i < 5; i++) wbyte(8'hC0 + 8'(i), acks[i]);
        mst.stop_cond();
        repeat (3) @(negedge clk);
        wr_ready = 1'h1;
        repeat (20) @(negedge clk);
        // two buffer entries plus the word held at the link: first three acked, rest refused
        `CHK({a0, a1, acks}, 7'h67);
        `CHK(got.size(), 3);
        foreach (got[k]) `CHK(got[k], {8'h40 + 8'(k), 8'hC0 + 8'(k)});
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'h0;
        repeat (50) @(negedge clk);
        wr_ready = 1'h1;
        t_write();
        t_wrong_addr();
        t_read(1'h0);
        t_read(1'h1);
        repeat (100) @(negedge clk);
        slow = 1'h0;
        t_stall();
        end_of_test();
    end
    initial begin
        #600us;
        bad_count++;
        $display("Error %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
